// ==== pmvl_top.sv ====
// program fetch sequencer with fixed reset and interrupt vector layout
`timescale 1ns/1ps
module pmvl_top import pmvl_pkg::*; #(
    parameter int DEPTH = PM_DEPTH_DEF
) (
    // clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 SYS_RST,
    // master clear pin and programmer entry
    input  wire logic                 MASTER_CLEAR_INPUT_N,
    input  wire logic                 PROG_ENTRY,
    output logic                      PROG_MODE,
    // core sequencing requests
    input  wire logic                 STEP_FWD,
    input  wire logic                 STEP_BACK,
    input  wire logic                 JUMP_VALID,
    input  wire logic [PM_ADDR_W-1:0] JUMP_ADDR,
    input  wire logic                 IRQ_VALID,
    input  wire logic [IRQ_ID_W-1:0]  IRQ_ID,
    input  wire logic                 ALT_TABLE,
    output logic                      IRQ_TAKEN,
    // instruction fetch result
    output logic [PM_ADDR_W-1:0]      PC,
    output logic                      FETCH_VALID,
    output logic [PM_ADDR_W-1:0]      FETCH_ADDR,
    output logic [PM_WORD_W-1:0]      FETCH_INSTR,
    output logic                      RESERVED_EXEC,
    // table read of one 16-bit word
    input  wire logic                 TBL_RD,
    input  wire logic [PM_ADDR_W-1:0] TBL_ADDR,
    output logic                      TBL_VALID,
    output logic [PM_HALF_W-1:0]      TBL_DATA,
    // programmer write of one 24-bit location
    input  wire logic                 PROG_WR,
    input  wire logic [PM_ADDR_W-1:0] PROG_ADDR,
    input  wire logic [PM_WORD_W-1:0] PROG_DATA
);
    pmvl_mem_if     mif ();
    pmvl_state_type state_q;
    logic [23:0]    pc_q;
    logic           prog_q;
    logic           rst_i;
    logic           irq_ok;
    logic [23:0]    vec_addr;
    logic [23:0]    vec_q;
    logic           fetch_valid_q;
    logic [23:0]    fetch_addr_q;
    logic           reserved_q;
    logic           tbl_valid_q;
    logic           irq_taken_q;

    pmvl_pmem #(.DEPTH(DEPTH)) u_pmem (
        .clk (CORE_CLK),
        .rst (SYS_RST),
        .mif (mif)
    );

    // the pin and the system reset both restart the core
    assign rst_i = SYS_RST || !MASTER_CLEAR_INPUT_N;

    // out-of-range ids are ignored so no source can alias another's entry
    assign irq_ok   = IRQ_VALID && (IRQ_ID < IRQ_COUNT);
    assign vec_addr = ALT_TABLE ? AIVT_BASE + AIVT_ENTRY_OFS + {16'h0000, IRQ_ID, 1'b0}
                                : IVT_BASE + {16'h0000, IRQ_ID, 1'b0};

    // programming entry is latched while the pin holds the device in reset
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            prog_q <= 1'b0;
        end else if (!MASTER_CLEAR_INPUT_N) begin
            prog_q <= PROG_ENTRY;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            state_q <= ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (prog_q) begin
                        state_q <= ST_PROG;
                    end else if (irq_ok) begin
                        state_q <= ST_VEC;
                    end
                end
                ST_VEC: begin
                    state_q <= ST_VEC_TAKE;
                end
                ST_VEC_TAKE: begin
                    state_q <= ST_RUN;
                end
                ST_PROG: begin
                    state_q <= ST_PROG;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            vec_q <= IVT_BASE;
        end else if (state_q == ST_RUN && irq_ok) begin
            vec_q <= vec_addr;
        end
    end

    // redirects have priority over sequential steps; bit 0 is always forced low
    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            pc_q <= PC_RESET;
        end else if (state_q == ST_VEC_TAKE) begin
            pc_q <= {mif.f_word[23:1], 1'b0};
        end else if (state_q == ST_RUN && !prog_q && !irq_ok) begin
            if (JUMP_VALID) begin
                pc_q <= {JUMP_ADDR[23:1], 1'b0};
            end else if (STEP_BACK) begin
                pc_q <= pc_q - PC_STEP;
            end else if (STEP_FWD) begin
                pc_q <= pc_q + PC_STEP;
            end
        end
    end

    always_comb begin
        mif.f_en   = (state_q == ST_RUN || state_q == ST_VEC) && !rst_i;
        mif.f_addr = (state_q == ST_VEC) ? vec_q : pc_q;
        mif.t_en   = TBL_RD && !rst_i;
        mif.t_addr = TBL_ADDR;
        mif.w_en   = PROG_WR && prog_q && !rst_i;
        mif.w_addr = {PROG_ADDR[23:1], 1'b0};
        mif.w_word = PROG_DATA;
    end

    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            fetch_valid_q <= 1'b0;
            fetch_addr_q  <= PC_RESET;
        end else begin
            fetch_valid_q <= (state_q == ST_RUN) && !prog_q;
            fetch_addr_q  <= pc_q;
        end
    end

    // flags an instruction fetched from the vector area past the reset pair
    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            reserved_q <= 1'b0;
        end else begin
            reserved_q <= (state_q == ST_RUN) && !prog_q
                          && pc_q >= IVT_BASE && pc_q < RESERVED_LIMIT;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (rst_i) begin
            tbl_valid_q <= 1'b0;
            irq_taken_q <= 1'b0;
        end else begin
            tbl_valid_q <= TBL_RD;
            irq_taken_q <= (state_q == ST_RUN) && !prog_q && irq_ok;
        end
    end

    assign PROG_MODE     = prog_q;
    assign IRQ_TAKEN     = irq_taken_q;
    assign PC            = pc_q;
    assign FETCH_VALID   = fetch_valid_q;
    assign FETCH_ADDR    = fetch_addr_q;
    assign FETCH_INSTR   = mif.f_word;
    assign RESERVED_EXEC = reserved_q;
    assign TBL_VALID     = tbl_valid_q;
    assign TBL_DATA      = mif.t_half;

    AST_PC_EVEN: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !pc_q[0])
        else $error("program counter left lower-word alignment");

    AST_STEP_FWD: assert property (@(posedge CORE_CLK) disable iff (rst_i)
        state_q == ST_RUN && !prog_q && !irq_ok && !JUMP_VALID && !STEP_BACK && STEP_FWD
        |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("forward step did not add two");

    AST_STEP_BACK: assert property (@(posedge CORE_CLK) disable iff (rst_i)
        state_q == ST_RUN && !prog_q && !irq_ok && !JUMP_VALID && STEP_BACK
        |=> pc_q == $past(pc_q) - PC_STEP)
        else $error("backward step did not subtract two");

    AST_RESET_FETCH_ZERO: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        rst_i ##1 !rst_i && !prog_q |-> mif.f_en && mif.f_addr == RESET_VECTOR_ADDR
        ##1 FETCH_VALID && FETCH_ADDR == RESET_VECTOR_ADDR)
        else $error("first fetch after reset not at address zero");

    AST_VEC_IN_RESERVED: assert property (@(posedge CORE_CLK) disable iff (rst_i)
        state_q == ST_VEC |-> mif.f_addr >= IVT_BASE && mif.f_addr <= AIVT_END
        && (mif.f_addr <= IVT_END || mif.f_addr >= AIVT_BASE))
        else $error("vector fetch outside the vector tables");

    AST_VEC_DISTINCT: assert property (@(posedge CORE_CLK) disable iff (rst_i)
        state_q == ST_RUN && !prog_q && irq_ok && !ALT_TABLE
        |=> mif.f_addr == IVT_BASE + {16'h0000, $past(IRQ_ID), 1'b0}
        ##2 pc_q == {$past(mif.f_word[23:1]), 1'b0})
        else $error("interrupt not dispatched through its own entry");

    AST_CLEAR_RESETS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        !MASTER_CLEAR_INPUT_N |=> pc_q == PC_RESET && state_q == ST_RUN
        && prog_q == $past(PROG_ENTRY))
        else $error("master clear did not reset or latch programming entry");

    AST_PROG_HOLDS_CORE: assert property (@(posedge CORE_CLK) disable iff (rst_i)
        prog_q && state_q == ST_PROG |=> !FETCH_VALID && $stable(pc_q))
        else $error("core ran while in programming mode");
endmodule : pmvl_top

// ==== pmvl_pkg.sv ====
// constants for the program memory and fixed vector layout
package pmvl_pkg;
    localparam int          PM_ADDR_W        = 24;
    localparam int          PM_WORD_W        = 24;
    localparam int          PM_HALF_W        = 16;
    localparam int          PM_DEPTH_DEF     = 1024;
    localparam int          IRQ_ID_W         = 7;
    localparam logic [23:0] RESET_VECTOR_ADDR = 24'h000000;
    localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
    localparam logic [23:0] IVT_BASE         = 24'h000004;
    localparam logic [23:0] IVT_END          = 24'h0000FF;
    localparam logic [23:0] AIVT_BASE        = 24'h000100;
    localparam logic [23:0] AIVT_END         = 24'h0001FF;
    localparam logic [23:0] AIVT_ENTRY_OFS   = 24'h000004;
    localparam logic [23:0] RESERVED_LIMIT   = 24'h000200;
    localparam logic [23:0] PC_STEP          = 24'h000002;
    localparam logic [23:0] PC_RESET         = RESET_VECTOR_ADDR;
    localparam logic [6:0]  IRQ_COUNT        = 7'h7E;
    localparam logic [7:0]  UPPER_BYTE_FILL  = 8'h00;
    localparam int          UPPER_LSB        = 16;
    typedef enum logic [1:0] {ST_RUN, ST_VEC, ST_VEC_TAKE, ST_PROG} pmvl_state_type;
endpackage : pmvl_pkg

// ==== pmvl_mem_if.sv ====
// carrier between the fetch sequencer and the program memory array
`timescale 1ns/1ps
interface pmvl_mem_if;
    logic        f_en;
    logic [23:0] f_addr;
    logic [23:0] f_word;
    logic        t_en;
    logic [23:0] t_addr;
    logic [15:0] t_half;
    logic        w_en;
    logic [23:0] w_addr;
    logic [23:0] w_word;
    modport ctrl (output f_en, f_addr, t_en, t_addr, w_en, w_addr, w_word,
                  input  f_word, t_half);
    modport mem  (input  f_en, f_addr, t_en, t_addr, w_en, w_addr, w_word,
                  output f_word, t_half);
endinterface : pmvl_mem_if

// ==== pmvl_pmem.sv ====
// program memory array: 24-bit locations, lower/upper word view
`timescale 1ns/1ps
module pmvl_pmem import pmvl_pkg::*; #(
    parameter int DEPTH = PM_DEPTH_DEF
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // access port
    pmvl_mem_if.mem   mif
);
    localparam int IW = $clog2(DEPTH);

    logic [PM_WORD_W-1:0] mem_q [DEPTH];
    logic [IW-1:0]        f_idx;
    logic [IW-1:0]        t_idx;
    logic [IW-1:0]        w_idx;
    logic                 f_in;
    logic                 t_in;
    logic                 w_in;
    logic [PM_WORD_W-1:0] t_word;

    // one location per lower-word address, so the index drops address bit 0
    assign f_idx  = mif.f_addr[IW:1];
    assign t_idx  = mif.t_addr[IW:1];
    assign w_idx  = mif.w_addr[IW:1];
    assign f_in   = (mif.f_addr[23:1] < 23'(DEPTH));
    assign t_in   = (mif.t_addr[23:1] < 23'(DEPTH));
    assign w_in   = (mif.w_addr[23:1] < 23'(DEPTH));
    assign t_word = t_in ? mem_q[t_idx] : '0;

    always_ff @(posedge clk) begin
        if (mif.w_en && w_in) begin
            mem_q[w_idx] <= mif.w_word;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mif.f_word <= '0;
        end else if (mif.f_en) begin
            mif.f_word <= f_in ? mem_q[f_idx] : '0;
        end
    end

    // even address gives the lower word, odd the upper with its top byte zero
    always_ff @(posedge clk) begin
        if (rst) begin
            mif.t_half <= '0;
        end else if (mif.t_en) begin
            mif.t_half <= mif.t_addr[0] ? {UPPER_BYTE_FILL, t_word[23:UPPER_LSB]}
                                        : t_word[15:0];
        end
    end

    AST_UPPER_BYTE_ZERO: assert property (@(posedge clk) disable iff (rst)
        mif.t_en && mif.t_addr[0] |=> mif.t_half[15:8] == UPPER_BYTE_FILL)
        else $error("upper word top byte not zero");

    AST_ODD_IS_UPPER: assert property (@(posedge clk) disable iff (rst)
        mif.t_en && mif.t_addr[0] && t_in |=> mif.t_half[7:0] == $past(t_word[23:16]))
        else $error("odd address did not return the upper word");

    // writes only happen while the core is held, so check the stored word itself
    AST_WORD_24_BITS: assert property (@(posedge clk) disable iff (rst)
        mif.w_en && w_in |=> mem_q[$past(w_idx)] == $past(mif.w_word))
        else $error("stored location lost bits of its 24-bit word");
endmodule : pmvl_pmem

// ==== pmvl_prog_model.sv ====
// programmer model: enters programming through the clear pin, loads an image, leaves
`timescale 1ns/1ps
module pmvl_prog_model import pmvl_pkg::*; #(
    parameter int DEPTH = 256
) (
    // clock and start
    input  wire logic        clk,
    input  wire logic        go,
    // pin and write port
    output logic             clear_n,
    output logic             entry,
    output logic             wr,
    output logic [23:0]      addr,
    output logic [23:0]      data,
    output logic             done
);
    // image pattern; word 0/2 stand in for the jump and its target
    function automatic logic [23:0] img(input logic [23:0] a);
        return {a[7:0] ^ 8'hC3, a[15:0] ^ 16'h5A5A};
    endfunction : img

    initial begin
        {clear_n, entry, wr, addr, data, done} = {2'b10, 1'b0, 48'h0, 1'b0};
        wait (go);
        @(posedge clk);
        clear_n <= 1'b0;
        entry   <= 1'b1;
        repeat (2) @(posedge clk);
        clear_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < DEPTH; i++) begin
            wr   <= 1'b1;
            addr <= 24'(2 * i);
            data <= img(24'(2 * i));
            @(posedge clk);
        end
        // released lines must not keep the last value
        wr      <= 1'b0;
        addr    <= ~addr;
        data    <= ~data;
        clear_n <= 1'b0;
        entry   <= 1'b0;
        repeat (2) @(posedge clk);
        clear_n <= 1'b1;
        done    <= 1'b1;
    end
endmodule : pmvl_prog_model

// ==== testbench.sv ====
// self-checking bench for the fetch sequencer and vector layout
`timescale 1ns/1ps
module testbench import pmvl_pkg::*;;
    localparam int DEPTH = 256;
    logic        core_clk, sys_rst, go, step_fwd, step_back, jump_valid;
    logic        irq_valid, alt_table, tbl_rd, tb_wr, pj, pb, pf;
    logic [23:0] jump_addr, tbl_addr, tb_addr, e_pc, e_prev, pa;
    logic [6:0]  irq_id;
    wire logic   clr_n, entry, pm_wr, prog_mode, irq_taken, fetch_valid, rsv, tbl_valid, done;
    wire logic [23:0] pm_addr, pm_data, pc, fetch_addr, fetch_instr;
    wire logic [15:0] tbl_data;
    int          err_total = 0;
    int          n_tests = 0;
    int          seed = 32'h9FE12B2A;
    logic [23:0] ids_c [5] = '{24'h000020, 24'h000021, 24'h000000, 24'h000001, 24'h0001FF};

    pmvl_prog_model #(.DEPTH(DEPTH)) pm (.clk(core_clk), .go(go), .clear_n(clr_n),
        .entry(entry), .wr(pm_wr), .addr(pm_addr), .data(pm_data), .done(done));
    pmvl_top #(.DEPTH(DEPTH)) dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .MASTER_CLEAR_INPUT_N(clr_n), .PROG_ENTRY(entry), .PROG_MODE(prog_mode),
        .STEP_FWD(step_fwd), .STEP_BACK(step_back), .JUMP_VALID(jump_valid),
        .JUMP_ADDR(jump_addr), .IRQ_VALID(irq_valid), .IRQ_ID(irq_id), .ALT_TABLE(alt_table),
        .IRQ_TAKEN(irq_taken), .PC(pc), .FETCH_VALID(fetch_valid), .FETCH_ADDR(fetch_addr),
        .FETCH_INSTR(fetch_instr), .RESERVED_EXEC(rsv), .TBL_RD(tbl_rd), .TBL_ADDR(tbl_addr),
        .TBL_VALID(tbl_valid), .TBL_DATA(tbl_data), .PROG_WR(pm_wr | tb_wr),
        .PROG_ADDR(tb_wr ? tb_addr : pm_addr), .PROG_DATA(tb_wr ? 24'hFFFFFF : pm_data));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // locations beyond the array read as zero
    function automatic logic [23:0] fexp(input logic [23:0] a);
        return (a < 24'(2 * DEPTH)) ? pm.img({a[23:1], 1'b0}) : 24'h000000;
    endfunction : fexp

    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task rst_chk(input bit with_img);
        @(posedge core_clk) sys_rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) chk("pc_in_reset", pc, 24'h000000);
        chk("fetch_valid_in_reset", fetch_valid, 24'h0);
        @(posedge core_clk) sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) chk("first_fetch_addr", fetch_addr, RESET_VECTOR_ADDR);
        chk("first_fetch_valid", fetch_valid, 24'h1);
        if (with_img) chk("first_fetch_word", fetch_instr, fexp(24'h0));
        chk("prog_mode_cleared", prog_mode, 24'h0);
        e_pc = 24'h000000;
        $display("test reset done");
    endtask : rst_chk

    task t_tbl(input logic [23:0] a);
        logic [23:0] w;
        w = fexp(a);
        @(posedge core_clk) tbl_rd <= 1'b1;
        tbl_addr <= a;
        @(posedge core_clk) tbl_rd <= 1'b0;
        @(negedge core_clk) chk("tbl_valid", tbl_valid, 24'h1);
        chk("tbl_data", tbl_data, a[0] ? {8'h00, w[23:16]} : w[15:0]);
    endtask : t_tbl

    task t_steps;
        logic [3:0] r;
        {pj, pb, pf} = 3'b000;
        for (int i = 0; i < 300; i++) begin
            @(posedge core_clk);
            e_prev = e_pc;
            e_pc = pj ? {pa[23:1], 1'b0} : pb ? e_pc - PC_STEP : pf ? e_pc + PC_STEP : e_pc;
            r = 4'($random(seed));
            pa = 24'($random(seed)) & 24'h0003FF;
            {pj, pb, pf} = {r[3] & r[2], r[1], r[0]};
            {jump_valid, step_back, step_fwd} <= {pj, pb, pf};
            jump_addr <= pa;
            @(negedge core_clk) chk("pc", pc, e_pc);
            chk("fetch_addr", fetch_addr, e_prev);
            chk("fetch_word", fetch_instr, fexp(e_prev));
            chk("reserved_exec", rsv, 24'(e_prev >= 24'h4 && e_prev <= 24'h1FF));
        end
        @(posedge core_clk) {jump_valid, step_back, step_fwd} <= 3'b000;
        @(posedge core_clk) e_pc = pj ? {pa[23:1], 1'b0} : pb ? e_pc - PC_STEP : pf ? e_pc + PC_STEP : e_pc;
        $display("test steps done");
    endtask : t_steps

    task t_irq;
        logic [6:0]  ids [6];
        logic [23:0] ent;
        ids = '{7'd0, 7'd1, 7'd63, 7'd125, 7'd126, 7'd127};
        for (int k = 0; k < 12; k++) begin
            ent = (k[0] ? AIVT_BASE + AIVT_ENTRY_OFS : IVT_BASE) + 24'(2 * ids[k / 2]);
            @(posedge core_clk) irq_valid <= 1'b1;
            {irq_id, alt_table} <= {ids[k / 2], k[0]};
            @(posedge core_clk) irq_valid <= 1'b0;
            @(negedge core_clk) chk("irq_taken", irq_taken, 24'(ids[k / 2] < 7'd126));
            if (ids[k / 2] < 7'd126) e_pc = fexp(ent) & 24'hFFFFFE;
            repeat (2) @(posedge core_clk);
            @(negedge core_clk) chk("irq_pc", pc, e_pc);
            repeat (2) @(posedge core_clk);
        end
        $display("test interrupts done");
    endtask : t_irq

    task final_report;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        {sys_rst, go, step_fwd, step_back, jump_valid, irq_valid, alt_table, tbl_rd, tb_wr} = 9'h100;
        {jump_addr, tbl_addr, tb_addr, irq_id} = '0;
        rst_chk(1'b0);
        go <= 1'b1;
        for (int i = 0; i < 100 && pm_wr !== 1'b1; i++) @(posedge core_clk);
        @(negedge core_clk) chk("prog_mode_entered", prog_mode, 24'h1);
        for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge core_clk);
        chk("prog_done", done, 24'h1);
        $display("test programming done");
        rst_chk(1'b1);
        // writes outside programming mode must be dropped
        @(posedge core_clk) tb_wr <= 1'b1;
        tb_addr <= 24'h000020;
        @(posedge core_clk) tb_wr <= 1'b0;
        foreach (ids_c[i]) t_tbl(ids_c[i]);
        for (int i = 0; i < 30; i++) t_tbl(24'($random(seed)) & 24'h0001FF);
        $display("test table reads done");
        t_steps();
        t_irq();
        rst_chk(1'b1);
        final_report();
    end

    initial begin
        #(20 * 20000);
        err_total++;
        final_report();
    end
endmodule : testbench
